// File: pcm_fmt_pkg.sv
// Purpose: constants shared by the pcm frame and track formatter
// Assumes: 24-bit words, msb (bit 23) shifted first
// Notes:   register offsets are byte addresses on the plain register port
package pcm_fmt_pkg;
    localparam int          WORD_W     = 24;           // formatted word width
    localparam int          INFO_W     = 16;           // information field width
    localparam int          ADDR_W     = 8;            // register address width
    localparam int          DATA_W     = 32;           // register data width
    localparam int          MAX_TRACKS = 4;            // tracks per bus at most
    localparam logic [23:0] SYNC_WORD  = 24'hFAF320;   // frame sync pattern
    localparam logic [15:0] FILL_INFO  = 16'hAAAA;     // fill information field
    localparam logic [15:0] CRC_POLY   = 16'h8005;     // x16+x15+x2+1
    localparam logic [15:0] CRC_INIT   = 16'h0000;     // fcs start value
    localparam logic [8:0]  FRAME_MIN  = 9'h081;       // 129 words, lowest legal
    localparam logic [8:0]  FRAME_MAX  = 9'h1FF;       // 511 words, highest legal
    localparam logic [8:0]  FRAME_RST  = 9'h100;       // 256 words after reset
    localparam logic [1:0]  TIME_WORDS = 2'h3;         // high, low, microsecond
    localparam logic [15:0] RATE_RST   = 16'h0001;     // half-bit period, clocks
    localparam logic [23:0] LABEL_RST  = 24'h000000;   // header labels after reset
    localparam logic [7:0]  CTRL_RST   = 8'h00;        // disabled after reset
    // register offsets
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_FLEN   = 8'h04;
    localparam logic [7:0]  OFS_RATE   = 8'h08;
    localparam logic [7:0]  OFS_LABEL  = 8'h0C;
    localparam logic [7:0]  OFS_STAT   = 8'h10;
    localparam logic [7:0]  OFS_FCNT   = 8'h14;
    // control field positions
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_TIME  = 1;
    localparam int          CTRL_CRC   = 2;
    localparam int          CTRL_DROP  = 3;
    localparam int          CTRL_CODE  = 4;            // two bits
    localparam int          CTRL_TK    = 6;            // two bits, count minus one
    // line codes
    localparam logic [1:0]  CODE_NRZ   = 2'h0;
    localparam logic [1:0]  CODE_RNRZ  = 2'h1;
    localparam logic [1:0]  CODE_BIPH  = 2'h2;
    // kinds of word placed in a slot
    typedef enum logic [1:0] {K_SYNC, K_TIME, K_CRC, K_DATA} word_kind_t;

    // bit times between successive track loads: 24 / track count
    function automatic logic [4:0] slot_bits(input logic [1:0] tk_m1);
        case (tk_m1)
            2'h0:    slot_bits = 5'h18;
            2'h1:    slot_bits = 5'h0C;
            2'h2:    slot_bits = 5'h08;
            default: slot_bits = 5'h06;
        endcase
    endfunction

    // fold one 24-bit word into the fcs, msb first
    function automatic logic [15:0] crc24(input logic [15:0] c, input logic [23:0] w);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            fb = r[15] ^ w[i];
            r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        crc24 = r;
    endfunction
endpackage

// File: pcm_frame_track_formatter.sv
// Purpose: frames 24-bit words into one composite or up to four staggered
//          track pcm streams with sync, time, fill and crc words
// Assumes: inputs synchronous to i_clk; one word held between source and frame
// Notes:   the bit rate is set by a half-bit divider and stays fixed in use
//
// Summary of operation
// (RULE_01) composite output is a continuous class 2 stream
// (RULE_02) every word shifts out msb first
// (RULE_03) bit rate fixed by configured divider
// (RULE_04) words leave in arrival order
// (RULE_05) frame length between 129 and 511 words
// (RULE_06) each frame begins with sync FAF320
// (RULE_07) frame time: sync, high, low, microsecond, data
// (RULE_08) without frame time data follows sync
// (RULE_09) last slot is crc when on, else data
// (RULE_10) optional dropping of fill words
// (RULE_11) line code randomized nrz-l or bi-phase-level
// (RULE_12) software avoids randomized code below 200 kbit/s
// (RULE_13) track streams staggered by 24/track count bits
// (RULE_14) at most four tracks per bus
// (RULE_15) each track carries its own sync word
// (RULE_16) all tracks share one frame length
// (RULE_17) crc appended to every track frame
// (RULE_18) tracks one to three carry time words
// (RULE_19) words dealt round-robin over tracks
// (RULE_20) without time, data follows each track sync
// (RULE_21) every slot word is 24 bits
// (RULE_22) fill words carry AAAA information field
// (RULE_23) fcs uses x16+x15+x2+1, crc word excluded
// (RULE_24) no data at a slot gives fill word
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_track_formatter (
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_resetn,
    // register port
    input  wire logic [pcm_fmt_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [pcm_fmt_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [pcm_fmt_pkg::DATA_W-1:0] o_rdata,
    // formatted word source
    input  wire logic                          i_word_valid,
    input  wire logic [pcm_fmt_pkg::WORD_W-1:0] i_word,
    output logic                               o_word_ready,
    // time words
    input  wire logic [pcm_fmt_pkg::INFO_W-1:0] i_time_hi,
    input  wire logic [pcm_fmt_pkg::INFO_W-1:0] i_time_lo,
    input  wire logic [pcm_fmt_pkg::INFO_W-1:0] i_time_us,
    // serial streams
    output logic      [pcm_fmt_pkg::MAX_TRACKS-1:0] o_line,
    output logic                               o_bit_stb,
    output logic                               o_frame_start
);
    import pcm_fmt_pkg::*;

    // configuration and status registers
    logic [7:0]  ctrl_r, ctrl_nxt;             // control bits
    logic [8:0]  flen_r, flen_nxt;             // words per frame incl. sync
    logic [15:0] rate_r, rate_nxt;             // clocks per half bit
    logic [23:0] label_r, label_nxt;           // header labels
    logic [15:0] fcnt_r, fcnt_nxt;             // frames completed
    logic [31:0] rdata_r, rdata_nxt;           // read answer
    // sequencer state
    logic [15:0] div_r, div_nxt;               // half-bit divider
    logic        ph_r, ph_nxt;                 // half-bit phase
    logic [4:0]  bcnt_r, bcnt_nxt;             // bit in slot
    logic [1:0]  trk_r, trk_nxt;               // track to load next
    logic [8:0]  pos_r, pos_nxt;               // word position in track frame
    logic [1:0]  tw_r, tw_nxt;                 // time words issued this frame
    logic        hold_v_r, hold_v_nxt;         // holding word valid
    logic [23:0] hold_r, hold_nxt;             // holding word
    logic        rdy_r, rdy_nxt;               // source may hand a word
    logic        stb_r, stb_nxt;               // bit strobe out
    logic        fs_r, fs_nxt;                 // frame start pulse out
    // per-track state
    logic [23:0] sh_r  [MAX_TRACKS];           // output shifters
    logic [15:0] crc_r [MAX_TRACKS];           // running fcs per track
    logic [MAX_TRACKS-1:0] line_r;             // coded line levels
    // shared decode
    logic        en, time_en, crc_en, drop;
    logic [1:0]  code, tk_m1;
    logic [4:0]  sbits;
    logic        half_tick, adv, bit_tick, slot_end, load, stall, consume;
    word_kind_t  kind;
    logic [23:0] word;

    assign en      = ctrl_r[CTRL_EN];
    assign time_en = ctrl_r[CTRL_TIME];
    assign crc_en  = ctrl_r[CTRL_CRC];
    assign drop    = ctrl_r[CTRL_DROP];
    assign code    = ctrl_r[CTRL_CODE +: 2];
    assign tk_m1   = ctrl_r[CTRL_TK +: 2];     // field holds 1..4 tracks only (RULE_14)
    assign sbits   = slot_bits(tk_m1);         // stagger between tracks (RULE_13)

    // register port: writes take effect next edge, reads answer next cycle
    always_comb begin
        ctrl_nxt  = ctrl_r;
        flen_nxt  = flen_r;
        rate_nxt  = rate_r;
        label_nxt = label_r;
        rdata_nxt = '0;
        if (i_wr) begin
            if (i_addr == OFS_CTRL) begin
                ctrl_nxt = i_wdata[7:0];
            end else if (i_addr == OFS_FLEN) begin
                // out-of-range lengths are ignored so the frame stays legal
                if (i_wdata[8:0] >= FRAME_MIN && i_wdata[8:0] <= FRAME_MAX
                    && i_wdata[31:9] == '0) begin
                    flen_nxt = i_wdata[8:0];   // RULE_05
                end
            end else if (i_addr == OFS_RATE) begin
                rate_nxt = i_wdata[15:0];      // RULE_03
            end else if (i_addr == OFS_LABEL) begin
                label_nxt = i_wdata[23:0];
            end
        end
        if (i_rd) begin
            if (i_addr == OFS_CTRL) begin
                rdata_nxt = {24'h000000, ctrl_r};
            end else if (i_addr == OFS_FLEN) begin
                rdata_nxt = {23'h000000, flen_r};
            end else if (i_addr == OFS_RATE) begin
                rdata_nxt = {16'h0000, rate_r};
            end else if (i_addr == OFS_LABEL) begin
                rdata_nxt = {8'h00, label_r};
            end else if (i_addr == OFS_STAT) begin
                rdata_nxt = {19'h00000, stall, hold_v_r, trk_r, pos_r};
            end else if (i_addr == OFS_FCNT) begin
                rdata_nxt = {16'h0000, fcnt_r};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r  <= CTRL_RST;
            flen_r  <= FRAME_RST;
            rate_r  <= RATE_RST;
            label_r <= LABEL_RST;
            rdata_r <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            flen_r  <= flen_nxt;
            rate_r  <= rate_nxt;
            label_r <= label_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // word choice for the slot about to load
    always_comb begin
        if (pos_r == '0) begin
            kind = K_SYNC;                      // RULE_06 RULE_15
        end else if (crc_en && pos_r >= flen_r - 9'h001) begin
            kind = K_CRC;                       // RULE_09 RULE_17
        end else if (time_en && tw_r < TIME_WORDS) begin
            kind = K_TIME;                      // RULE_07 RULE_18
        end else begin
            kind = K_DATA;                      // RULE_08 RULE_20
        end
        case (kind)
            K_SYNC:  word = SYNC_WORD;
            K_CRC:   word = {label_r[3:0], label_r[11:8], crc_r[trk_r]};
            K_TIME: begin
                case (tw_r)
                    2'h0:    word = {label_r[3:0], label_r[15:12], i_time_hi};
                    2'h1:    word = {label_r[3:0], label_r[19:16], i_time_lo};
                    default: word = {label_r[3:0], label_r[23:20], i_time_us};
                endcase
            end
            // fill keeps the stream continuous when the source is idle
            default: word = hold_v_r ? hold_r
                                     : {label_r[3:0], label_r[7:4], FILL_INFO}; // RULE_22 RULE_24
        endcase
    end

    // timing: half ticks from the divider, a bit every second half
    assign half_tick = en && (div_r + 16'h0001 >= rate_r);
    assign slot_end  = (bcnt_r == sbits - 5'h01);
    // drop mode freezes the line instead of sending fill
    assign stall     = en && drop && slot_end && ph_r && kind == K_DATA
                       && !hold_v_r;            // RULE_10
    assign adv       = half_tick && !stall;
    assign bit_tick  = adv && ph_r;
    assign load      = bit_tick && slot_end;
    assign consume   = load && kind == K_DATA && hold_v_r;

    // sequencer: slot, track, position and holding word
    always_comb begin
        div_nxt    = half_tick ? 16'h0000 : div_r + 16'h0001;
        ph_nxt     = adv ? !ph_r : ph_r;
        bcnt_nxt   = bcnt_r;
        trk_nxt    = trk_r;
        pos_nxt    = pos_r;
        tw_nxt     = tw_r;
        fcnt_nxt   = fcnt_r;
        fs_nxt     = load && kind == K_SYNC && trk_r == 2'h0;
        stb_nxt    = bit_tick;
        hold_v_nxt = hold_v_r && !consume;     // RULE_04
        hold_nxt   = hold_r;
        if (bit_tick) begin
            bcnt_nxt = slot_end ? 5'h00 : bcnt_r + 5'h01;
        end
        if (load) begin
            if (kind == K_TIME) begin
                tw_nxt = tw_r + 2'h1;
            end
            // deal words track by track, position steps after last track
            if (trk_r >= tk_m1) begin
                trk_nxt = 2'h0;                 // RULE_19
                if (pos_r >= flen_r - 9'h001) begin
                    pos_nxt  = '0;              // RULE_16 RULE_24
                    tw_nxt   = 2'h0;
                    fcnt_nxt = fcnt_r + 16'h0001;
                end else begin
                    pos_nxt = pos_r + 9'h001;
                end
            end else begin
                trk_nxt = trk_r + 2'h1;
            end
        end
        if (i_word_valid && rdy_r) begin
            hold_v_nxt = 1'b1;                  // one word only, order kept
            hold_nxt   = i_word;
        end
        if (!en) begin
            div_nxt  = '0;
            ph_nxt   = 1'b0;
            bcnt_nxt = '0;
            trk_nxt  = '0;
            pos_nxt  = '0;
            tw_nxt   = '0;
        end
        rdy_nxt = !hold_v_nxt;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_r    <= '0;
            ph_r     <= 1'b0;
            bcnt_r   <= '0;
            trk_r    <= '0;
            pos_r    <= '0;
            tw_r     <= '0;
            fcnt_r   <= '0;
            fs_r     <= 1'b0;
            stb_r    <= 1'b0;
            hold_v_r <= 1'b0;
            hold_r   <= '0;
            rdy_r    <= 1'b0;
        end else begin
            div_r    <= div_nxt;
            ph_r     <= ph_nxt;
            bcnt_r   <= bcnt_nxt;
            trk_r    <= trk_nxt;
            pos_r    <= pos_nxt;
            tw_r     <= tw_nxt;
            fcnt_r   <= fcnt_nxt;
            fs_r     <= fs_nxt;
            stb_r    <= stb_nxt;
            hold_v_r <= hold_v_nxt;
            hold_r   <= hold_nxt;
            rdy_r    <= rdy_nxt;
        end
    end

    // per-track shifter, fcs, randomizer and line coder
    for (genvar g = 0; g < MAX_TRACKS; g++) begin : g_trk
        logic [23:0] sh_nxt;                    // shifter next value
        logic [15:0] crc_nxt;                   // fcs next value
        logic [14:0] scr_r, scr_nxt;            // randomizer history
        logic        rb;                        // randomized current bit
        logic        lv_nxt;                    // coded level next value
        logic        ld;                        // this track loads now
        always_comb begin
            ld      = load && trk_r == 2'(g);
            sh_nxt  = sh_r[g];
            crc_nxt = crc_r[g];
            scr_nxt = scr_r;
            rb      = sh_r[g][23] ^ scr_r[13] ^ scr_r[14];
            if (ld) begin
                sh_nxt = word;                  // RULE_21
                if (kind == K_SYNC) begin
                    crc_nxt = crc24(CRC_INIT, word);
                end else if (kind == K_CRC) begin
                    crc_nxt = CRC_INIT;         // crc word left out of its own fcs
                end else begin
                    crc_nxt = crc24(crc_r[g], word); // RULE_23
                end
            end else if (bit_tick) begin
                sh_nxt = {sh_r[g][22:0], 1'b0}; // RULE_02
            end
            if (bit_tick) begin
                scr_nxt = {scr_r[13:0], rb};
            end
            case (code)
                CODE_RNRZ: lv_nxt = rb;         // RULE_11
                CODE_BIPH: lv_nxt = ph_r ? !sh_r[g][23] : sh_r[g][23]; // RULE_11
                default:   lv_nxt = sh_r[g][23];
            endcase
            // idle tracks and a disabled block hold the line low
            if (!en || 2'(g) > tk_m1) begin
                lv_nxt = 1'b0;                  // RULE_01
            end
        end
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                sh_r[g]   <= '0;
                crc_r[g]  <= CRC_INIT;
                scr_r     <= '0;
                line_r[g] <= 1'b0;
            end else begin
                sh_r[g]   <= sh_nxt;
                crc_r[g]  <= crc_nxt;
                scr_r     <= scr_nxt;
                line_r[g] <= lv_nxt;
            end
        end
    end

    assign o_rdata       = rdata_r;
    assign o_word_ready  = rdy_r;
    assign o_line        = line_r;
    assign o_bit_stb     = stb_r;
    assign o_frame_start = fs_r;

    // checks
    sequence s_load_kind(word_kind_t k);
        load && kind == k;
    endsequence
    AST_SYNC_LOAD: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_06
        s_load_kind(K_SYNC) |=> sh_r[$past(trk_r)] == SYNC_WORD)
        else $error("sync word not loaded");
    AST_MSB_FIRST: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_02
        bit_tick && !(load && trk_r == 2'h0) |=> sh_r[0][23] == $past(sh_r[0][22]))
        else $error("bit order wrong");
    AST_FILL: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_22
        s_load_kind(K_DATA) ##0 !hold_v_r |=> sh_r[$past(trk_r)][15:0] == FILL_INFO)
        else $error("fill pattern wrong");
    AST_ORDER: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_04
        s_load_kind(K_DATA) ##0 hold_v_r |=> sh_r[$past(trk_r)] == $past(hold_r) && !hold_v_r)
        else $error("held word not sent");
    AST_CRC: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_23
        s_load_kind(K_CRC) |=> sh_r[$past(trk_r)][15:0] == $past(crc_r[trk_r])
                               && crc_r[$past(trk_r)] == CRC_INIT)
        else $error("crc word wrong");
    AST_TIME_HI: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_07
        s_load_kind(K_TIME) ##0 tw_r == 2'h0 |-> pos_r == 9'h001 ##1
        sh_r[$past(trk_r)][15:0] == $past(i_time_hi))
        else $error("high time word misplaced");
    AST_WRAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_24
        load && trk_r >= tk_m1 && pos_r >= flen_r - 9'h001 |=> pos_r == '0 && tw_r == '0)
        else $error("frame did not wrap");
    AST_DROP_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_10
        stall && !i_wr |=> $stable(bcnt_r) && $stable(sh_r[trk_r]) && !stb_r)
        else $error("stalled line moved");
    AST_FLEN: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_05
        flen_r >= FRAME_MIN && flen_r <= FRAME_MAX)
        else $error("frame length out of range");
    AST_SLOT: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE_13
        bcnt_r < sbits || $changed(tk_m1) || $past(!en))
        else $error("slot counter overran");
endmodule
`default_nettype wire

// File: pcm_track_recorder.sv
// Purpose: recorder model that takes the nrz-l composite stream off track 0
// Assumes: half-bit period of at least two clocks, so mid-bit sampling is safe
// Notes:   words are kept only after the first sync pattern is found
`timescale 1ns/1ps
`default_nettype none
module pcm_track_recorder (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // serial stream
    input  wire logic i_line,
    input  wire logic i_bit_stb
);
    logic [23:0] sh;    // last 24 bits seen
    logic [1:0]  dly;   // clocks since the bit strobe
    int          nb;    // bits into the word, -1 before lock
    logic [23:0] q[$];  // recorded words
    // sample two clocks after the strobe, clear of the line lag
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dly <= 2'h0;
            nb = -1;
            sh = 24'h000000;
            q.delete();
        end else begin
            dly <= i_bit_stb ? 2'h1 : (dly == 2'h1 ? 2'h2 : 2'h0);
            if (dly == 2'h2) begin
                sh = {sh[22:0], i_line};
                if (nb < 0) begin
                    if (sh == 24'hFAF320) begin
                        q.push_back(sh);
                        nb = 0;
                    end
                end else begin
                    nb = nb + 1;
                    if (nb == 24) begin
                        q.push_back(sh);
                        nb = 0;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: pcm_frame_track_formatter_bench.sv
// Purpose: self-checking bench for the pcm frame and track formatter
// Assumes: nrz-l composite on track 0, two clocks per half bit
// Notes:   shortest legal frame keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module pcm_frame_track_formatter_bench;
    import pcm_fmt_pkg::*;
    logic              clk;          // 25 MHz clock
    logic              resetn;       // active-low reset
    logic [7:0]        addr;         // register address
    logic [31:0]       wdata;        // register write data
    logic              wr;           // write strobe
    logic              rd;           // read strobe
    logic [31:0]       rdata;        // read answer
    logic              word_valid;   // source offers a word
    logic [23:0]       word;         // source word
    logic              word_ready;   // formatter takes a word
    logic [3:0]        line;         // coded track levels
    logic              bit_stb;      // one pulse per bit
    logic              fs;           // frame start pulse
    int                n_fs;         // frame start pulses since reset
    int                n_src;        // words the source offers
    int                sent;         // words taken so far
    int                err_total;    // mismatches
    int                total_checks; // comparisons
    logic [31:0]       rv;           // read result

    pcm_frame_track_formatter i_pcm_frame_track_formatter (
        .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_word_valid(word_valid),
        .i_word(word), .o_word_ready(word_ready), .i_time_hi(16'h1234),
        .i_time_lo(16'h5678), .i_time_us(16'h9ABC), .o_line(line),
        .o_bit_stb(bit_stb), .o_frame_start(fs));
    pcm_track_recorder i_pcm_track_recorder (
        .i_clk(clk), .i_resetn(resetn), .i_line(line[0]), .i_bit_stb(bit_stb));

    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // source holds each word until it is taken; values count up
    always @(posedge clk) begin
        if (!resetn) begin
            sent = 0;
            n_fs = 0;
        end else begin
            if (word_valid && word_ready) begin
                sent = sent + 1;
            end
            if (fs) begin
                n_fs = n_fs + 1;
            end
        end
        word_valid <= resetn && (sent < n_src);
        word       <= 24'h120000 + sent[23:0];
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // answer stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
    endtask

    // own fcs fold, msb first, x16+x15+x2+1 from zero
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction

    task automatic reg_test();
        rd_reg(OFS_CTRL, rv);
        chk("ctrl", rv, 32'h0);
        rd_reg(OFS_RATE, rv);
        chk("rate", rv, 32'h1);
        rd_reg(8'h18, rv);
        chk("unmapped", rv, 32'h0);
        rd_reg(OFS_FLEN, rv);
        chk("flen", rv, 32'h100);
        wr_reg(OFS_FLEN, 32'h80);
        rd_reg(OFS_FLEN, rv);
        chk("flen 128", rv, 32'h100);
        wr_reg(OFS_FLEN, 32'h200);
        rd_reg(OFS_FLEN, rv);
        chk("flen 512", rv, 32'h100);
        wr_reg(OFS_FLEN, 32'h1FF);
        rd_reg(OFS_FLEN, rv);
        chk("flen 511", rv, 32'h1FF);
    endtask

    // one 129-word track 0 frame plus the next sync, against a frame built here;
    // with several tracks track 0 gets every tracks-th data word
    task automatic run_frame(input logic [7:0] ctrl, input logic tm, input logic crc);
        logic [23:0] e;
        logic [15:0] fcs;
        int          d;
        fcs = 16'h0000;
        d   = 0;
        do_reset();
        wr_reg(OFS_FLEN, 32'h81);
        wr_reg(OFS_RATE, 32'h2);
        wr_reg(OFS_LABEL, 32'h654E71);
        n_src = 20;
        wr_reg(OFS_CTRL, {24'h0, ctrl}); // plain nrz-l code, two clocks per half bit
        for (int k = 0; k < 20000 && i_pcm_track_recorder.q.size() < 130; k++) begin
            @(posedge clk);
        end
        for (int p = 0; p < 130; p++) begin
            if (p == 0 || p == 129) begin
                e = 24'hFAF320;
            end else if (tm && p < 4) begin
                e = {4'h1, 4'h3 + p[3:0], p == 1 ? 16'h1234 : p == 2 ? 16'h5678 : 16'h9ABC};
            end else if (crc && p == 128) begin
                e = {8'h1E, fcs};
            end else if (d < 20) begin
                e = 24'h120000 + d[23:0];
                d = d + int'(ctrl[7:6]) + 1;
            end else begin
                e = 24'h17AAAA;
            end
            chk("word", {8'h0, i_pcm_track_recorder.q[p]}, {8'h0, e});
            fcs = fold(fcs, e);
        end
        chk("frame starts", n_fs, 32'h2);
        rd_reg(OFS_FCNT, rv);
        chk("frames", rv, 32'h1);
        if (ctrl[7:6] == 2'h0) begin
            chk("idle tracks", {29'h0, line[3:1]}, 32'h0);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        results();
    end

    initial begin
        resetn       = 1'b0;
        addr         = 8'h00;
        wdata        = 32'h0;
        wr           = 1'b0;
        rd           = 1'b0;
        word_valid   = 1'b0;
        word         = 24'h000000;
        n_src        = 0;
        err_total    = 0;
        total_checks = 0;
        do_reset();
        reg_test();
        run_frame(8'h03, 1'b1, 1'b0);
        run_frame(8'h05, 1'b0, 1'b1);
        run_frame(8'hC5, 1'b0, 1'b1);
        results();
    end
endmodule
`default_nettype wire
